// ==== rpis_pkg.sv ====
// Package with register map, field positions and sizes for the port interrupt status block.
package rpis_pkg;
  localparam int RPIS_PORTS = 2;
  localparam int RPIS_GPIOS = 4;
  localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
  localparam logic [7:0] CSI_RX_STATUS_ADDR = 8'h7A;
  localparam logic [7:0] PORT_INT_CTRL_HIGH_ADDR = 8'hD8;
  localparam logic [7:0] PORT_INT_CTRL_LOW_ADDR = 8'hD9;
  localparam logic [7:0] PORT_INT_STATUS_HIGH_ADDR = 8'hDA;
  localparam logic [7:0] PORT_INT_STATUS_LOW_ADDR = 8'hDB;
  localparam logic [7:0] FORWARD_GPIO_STATUS_ADDR = 8'hDC;
  localparam logic [7:0] FORWARD_GPIO_CTRL_ADDR = 8'hDD;
  localparam logic [7:0] SENSOR_RISE_STATUS_ADDR = 8'hDE;
  localparam logic [7:0] SENSOR_FALL_STATUS_ADDR = 8'hDF;
  localparam logic [7:0] RECEIVE_PORT_STATUS_ONE_ADDR = 8'h4D;
  localparam logic [7:0] RECEIVE_PORT_STATUS_TWO_ADDR = 8'h4E;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int HI_GPIO_BIT = 4;
  localparam int HI_SENSOR_BIT = 3;
  localparam int HI_ENCODE_BIT = 2;
  localparam int HI_SEQUENCE_BIT = 1;
  localparam int HI_CRC_BIT = 0;
  localparam int LO_LINE_LEN_BIT = 6;
  localparam int LO_LINE_CNT_BIT = 5;
  localparam int LO_BUFFER_BIT = 4;
  localparam int LO_CSI_BIT = 3;
  localparam int LO_PARITY_BIT = 2;
  localparam int LO_VALID_BIT = 1;
  localparam int LO_LOCK_BIT = 0;
  localparam logic [7:0] HI_MASK = 8'h1F;
  localparam logic [7:0] LO_MASK = 8'h7F;
endpackage

// ==== rpis_evt_if.sv ====
// Interface that carries one port's event pulses and read-clear strobes.
`timescale 1ns/1ps
interface rpis_evt_if;
  logic [7:0] hi_set;
  logic [7:0] lo_set;
  logic [7:0] hi_clr;
  logic [7:0] lo_clr;
  logic [7:0] hi_flags;
  logic [7:0] lo_flags;
  modport ctrl (output hi_set, output lo_set, output hi_clr, output lo_clr,
    input hi_flags, input lo_flags);
  modport flags (input hi_set, input lo_set, input hi_clr, input lo_clr,
    output hi_flags, output lo_flags);
endinterface

// ==== rpis_flags.sv ====
// Sticky status flags of one receive port, set wins over read clear.
`timescale 1ns/1ps
module rpis_flags
  import rpis_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  rpis_evt_if.flags evt
);
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hi_reg <= RESET_BYTE;
      lo_reg <= RESET_BYTE;
    end
    else
    begin
      hi_reg <= ((hi_reg & ~evt.hi_clr) | evt.hi_set) & HI_MASK;
      lo_reg <= ((lo_reg & ~evt.lo_clr) | evt.lo_set) & LO_MASK;
    end
  end

  assign evt.hi_flags = hi_reg;
  assign evt.lo_flags = lo_reg;
endmodule

// ==== rpis_gpio_sync.sv ====
// Three-stage synchroniser for forward GPIO levels with agreement filter.
`timescale 1ns/1ps
module rpis_gpio_sync
  import rpis_pkg::*;
#(
  parameter int WIDTH = RPIS_GPIOS
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // A change counts only once the last two stages agree.
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
        begin
          level_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign level_o = level_reg;
endmodule

// ==== rpis_top.sv ====
// Per-port interrupt status registers behind the byte register port.
`timescale 1ns/1ps
module rpis_top
  import rpis_pkg::*;
#(
  parameter int PORTS = RPIS_PORTS,
  parameter int GPIOS = RPIS_GPIOS
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [PORTS-1:0] encode_error_i,
  input wire logic [PORTS-1:0] sequence_error_i,
  input wire logic [PORTS-1:0] crc_error_i,
  input wire logic [PORTS-1:0] sensor_change_i,
  input wire logic [PORTS-1:0] line_length_change_i,
  input wire logic [PORTS-1:0] line_count_change_i,
  input wire logic [PORTS-1:0] buffer_overflow_i,
  input wire logic [PORTS-1:0] csi_error_i,
  input wire logic [PORTS-1:0] parity_error_i,
  input wire logic [PORTS-1:0] port_valid_i,
  input wire logic [PORTS-1:0] lock_i,
  input wire logic [PORTS*GPIOS-1:0] fwd_gpio_i,
  output logic [PORTS-1:0] port_select_o,
  output logic irq_o
);
  logic [7:0] port_select_reg;
  logic [PORTS-1:0] port_valid_d_reg;
  logic [PORTS-1:0] lock_d_reg;
  logic [PORTS-1:0] sensor_rise_read_reg;
  logic [PORTS-1:0] sensor_fall_read_reg;
  logic [7:0] ctrl_hi_reg [PORTS];
  logic [7:0] ctrl_lo_reg [PORTS];
  logic [7:0] gpio_ctrl_reg [PORTS];
  logic [GPIOS-1:0] gpio_event_reg [PORTS];
  logic [GPIOS-1:0] gpio_prev_reg [PORTS];
  logic [GPIOS-1:0] gpio_level [PORTS];
  logic [7:0] hi_flags [PORTS];
  logic [7:0] lo_flags [PORTS];
  logic [7:0] reg_rdata_reg;
  logic irq_reg;
  logic [PORTS-1:0] sel;
  logic [PORTS-1:0] rd_sel;
  logic [PORTS-1:0] pend;
  // Only the three error enables exist in the high control byte; the GPIO
  // flag above them is gated by its edge enables, and the sensor flag never raises the request.
  localparam logic [7:0] CTRL_HI_WRITABLE = (8'h01 << HI_ENCODE_BIT)
    | (8'h01 << HI_SEQUENCE_BIT)
    | (8'h01 << HI_CRC_BIT);

  // Bit n of the select byte opens port n to reads and writes.
  // Read clears reach only the lowest selected port, whose byte is the one
  // returned, so a read with two ports open keeps the other port's events.
  always_comb
  begin
    rd_sel = '0;
    for (int p = 0; p < PORTS; p++)
    begin
      sel[p] = port_select_reg[p];
    end
    for (int p = PORTS - 1; p >= 0; p--)
    begin
      if (port_select_reg[p])
      begin
        rd_sel = '0;
        rd_sel[p] = reg_rd_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      port_select_reg <= RESET_BYTE;
    end
    else if (reg_wr_i && reg_addr_i == PORT_SELECT_ADDR)
    begin
      port_select_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int p = 0; p < PORTS; p++)
      begin
        ctrl_hi_reg[p] <= RESET_BYTE;
        ctrl_lo_reg[p] <= RESET_BYTE;
        gpio_ctrl_reg[p] <= RESET_BYTE;
      end
    end
    else if (reg_wr_i)
    begin
      // A write reaches every selected port, so one access with both ports selected sets both.
      for (int p = 0; p < PORTS; p++)
      begin
        if (sel[p] && reg_addr_i == PORT_INT_CTRL_HIGH_ADDR)
        begin
          ctrl_hi_reg[p] <= reg_wdata_i & CTRL_HI_WRITABLE;
        end
        if (sel[p] && reg_addr_i == PORT_INT_CTRL_LOW_ADDR)
        begin
          ctrl_lo_reg[p] <= reg_wdata_i;
        end
        if (sel[p] && reg_addr_i == FORWARD_GPIO_CTRL_ADDR)
        begin
          gpio_ctrl_reg[p] <= reg_wdata_i;
        end
      end
    end
  end

  // A port already valid or locked when reset ends reports one change,
  // which matches a link that comes up after reset.
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      port_valid_d_reg <= '0;
      lock_d_reg <= '0;
    end
    else
    begin
      port_valid_d_reg <= port_valid_i;
      lock_d_reg <= lock_i;
    end
  end

  // Sensor flag clears only after both edge status bytes were read.
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sensor_rise_read_reg <= '0;
      sensor_fall_read_reg <= '0;
    end
    else
    begin
      for (int p = 0; p < PORTS; p++)
      begin
        if (sensor_change_i[p] || (sensor_rise_read_reg[p]
            && sensor_fall_read_reg[p]))
        begin
          sensor_rise_read_reg[p] <= 1'b0;
          sensor_fall_read_reg[p] <= 1'b0;
        end
        else
        begin
          if (rd_sel[p] && reg_addr_i == SENSOR_RISE_STATUS_ADDR)
          begin
            sensor_rise_read_reg[p] <= 1'b1;
          end
          if (rd_sel[p] && reg_addr_i == SENSOR_FALL_STATUS_ADDR)
          begin
            sensor_fall_read_reg[p] <= 1'b1;
          end
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < PORTS; g++)
    begin : port_g
      rpis_evt_if evt ();
      logic [GPIOS-1:0] gpio_edges;
      logic rd1;
      logic rd2;
      logic rdgpio;

      // Forward GPIO levels come from outside this clock, so they are synced.
      rpis_gpio_sync #(
        .WIDTH(GPIOS)
      ) u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(fwd_gpio_i[g*GPIOS +: GPIOS]),
        .level_o(gpio_level[g])
      );

      rpis_flags u_flags (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .evt(evt)
      );

      assign rd1 = rd_sel[g] && reg_addr_i == RECEIVE_PORT_STATUS_ONE_ADDR;
      assign rd2 = rd_sel[g] && reg_addr_i == RECEIVE_PORT_STATUS_TWO_ADDR;
      assign rdgpio = rd_sel[g] && reg_addr_i == FORWARD_GPIO_STATUS_ADDR;

      // Rise enables on even bits, fall enables on odd bits.
      always_comb
      begin
        for (int i = 0; i < GPIOS; i++)
        begin
          gpio_edges[i] = (gpio_ctrl_reg[g][2*i] && gpio_level[g][i]
            && !gpio_prev_reg[g][i]) || (gpio_ctrl_reg[g][2*i+1]
            && !gpio_level[g][i] && gpio_prev_reg[g][i]);
        end
      end

      always_ff @(posedge core_clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          gpio_prev_reg[g] <= '0;
          gpio_event_reg[g] <= '0;
        end
        else
        begin
          gpio_prev_reg[g] <= gpio_level[g];
          // A new edge in the read cycle survives the clear.
          gpio_event_reg[g] <= (rdgpio ? '0 : gpio_event_reg[g])
            | gpio_edges;
        end
      end

      always_comb
      begin
        evt.hi_set = 8'h00;
        evt.lo_set = 8'h00;
        evt.hi_clr = 8'h00;
        evt.lo_clr = 8'h00;
        evt.hi_set[HI_GPIO_BIT] = |gpio_edges;
        evt.hi_set[HI_SENSOR_BIT] = sensor_change_i[g];
        evt.hi_set[HI_ENCODE_BIT] = encode_error_i[g];
        evt.hi_set[HI_SEQUENCE_BIT] = sequence_error_i[g];
        evt.hi_set[HI_CRC_BIT] = crc_error_i[g];
        evt.lo_set[LO_LINE_LEN_BIT] = line_length_change_i[g];
        evt.lo_set[LO_LINE_CNT_BIT] = line_count_change_i[g];
        evt.lo_set[LO_BUFFER_BIT] = buffer_overflow_i[g];
        evt.lo_set[LO_CSI_BIT] = csi_error_i[g];
        evt.lo_set[LO_PARITY_BIT] = parity_error_i[g];
        evt.lo_set[LO_VALID_BIT] = port_valid_i[g]
          ^ port_valid_d_reg[g];
        evt.lo_set[LO_LOCK_BIT] = lock_i[g] ^ lock_d_reg[g];
        evt.hi_clr[HI_GPIO_BIT] = rdgpio;
        evt.hi_clr[HI_SENSOR_BIT] = sensor_rise_read_reg[g]
          && sensor_fall_read_reg[g];
        evt.hi_clr[HI_ENCODE_BIT] = rd2;
        evt.hi_clr[HI_SEQUENCE_BIT] = rd1;
        evt.hi_clr[HI_CRC_BIT] = rd1;
        evt.lo_clr[LO_LINE_LEN_BIT] = rd2;
        evt.lo_clr[LO_LINE_CNT_BIT] = rd2;
        evt.lo_clr[LO_BUFFER_BIT] = rd2;
        evt.lo_clr[LO_CSI_BIT] = rd_sel[g]
          && reg_addr_i == CSI_RX_STATUS_ADDR;
        evt.lo_clr[LO_PARITY_BIT] = rd1;
        evt.lo_clr[LO_VALID_BIT] = rd1;
        evt.lo_clr[LO_LOCK_BIT] = rd1;
      end

      assign hi_flags[g] = evt.hi_flags;
      assign lo_flags[g] = evt.lo_flags;
      // Flags latch always; only enabled ones raise the request.
      // Latched GPIO events were already gated by their edge enables.
      assign pend[g] = |(evt.hi_flags & ctrl_hi_reg[g])
        || |(evt.lo_flags & ctrl_lo_reg[g])
        || |gpio_event_reg[g];
    end
  endgenerate

  // Read data comes from the lowest selected port, one cycle later.
  // Unmapped addresses and port register reads with no port selected return zero.
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reg_rdata_reg <= RESET_BYTE;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_reg <= RESET_BYTE;
      if (reg_addr_i == PORT_SELECT_ADDR)
      begin
        reg_rdata_reg <= port_select_reg;
      end
      for (int p = PORTS - 1; p >= 0; p--)
      begin
        if (sel[p])
        begin
          unique case (reg_addr_i)
            PORT_INT_CTRL_HIGH_ADDR: reg_rdata_reg <= ctrl_hi_reg[p];
            PORT_INT_CTRL_LOW_ADDR: reg_rdata_reg <= ctrl_lo_reg[p];
            PORT_INT_STATUS_HIGH_ADDR: reg_rdata_reg <= hi_flags[p];
            PORT_INT_STATUS_LOW_ADDR: reg_rdata_reg <= lo_flags[p];
            FORWARD_GPIO_STATUS_ADDR: reg_rdata_reg <=
              {gpio_event_reg[p], gpio_level[p]};
            FORWARD_GPIO_CTRL_ADDR: reg_rdata_reg <= gpio_ctrl_reg[p];
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |pend;
    end
  end

  assign reg_rdata_o = reg_rdata_reg;
  assign irq_o = irq_reg;
  assign port_select_o = port_select_reg[PORTS-1:0];
endmodule

// ==== rpis_checker.sv ====
// Port-level checker for the port interrupt status block.
`timescale 1ns/1ps
module rpis_checker
  import rpis_pkg::*;
#(
  parameter int PORTS = RPIS_PORTS
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [PORTS-1:0] port_select_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // The host may sample late, so read data must not drift between reads.
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == RESET_BYTE)
    else $error("unmapped read not zero");
  a_high_reserved: assert property (
    reg_rd_i && reg_addr_i == PORT_INT_STATUS_HIGH_ADDR
    |=> (reg_rdata_o & ~HI_MASK) == 8'h00)
    else $error("high status reserved bits set");
  a_low_reserved: assert property (
    reg_rd_i && reg_addr_i == PORT_INT_STATUS_LOW_ADDR
    |=> (reg_rdata_o & ~LO_MASK) == 8'h00)
    else $error("low status reserved bit set");
  a_unselected_zero: assert property (
    reg_rd_i && port_select_o == '0 && reg_addr_i == FORWARD_GPIO_STATUS_ADDR
    |=> reg_rdata_o == 8'h00)
    else $error("read with no port selected not zero");
  a_select_write: assert property (
    reg_wr_i && reg_addr_i == PORT_SELECT_ADDR
    |=> port_select_o == $past(reg_wdata_i[PORTS-1:0]))
    else $error("port select not loaded");
  a_select_hold: assert property (
    !(reg_wr_i && reg_addr_i == PORT_SELECT_ADDR) |=> $stable(port_select_o))
    else $error("port select moved without a write");
  a_irq_fall_cause: assert property (
    $fell(irq_o) |-> $past(reg_rd_i, 2) || $past(reg_wr_i, 2))
    else $error("interrupt dropped without an access");
endmodule

bind rpis_top rpis_checker #(.PORTS(PORTS)) u_rpis_checker (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .port_select_o(port_select_o), .irq_o(irq_o));

// ==== rpis_host.sv ====
// Host model issuing single-byte register accesses.
`timescale 1ns/1ps
module rpis_host
(
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // Released lines are inverted so a stale value is never mistaken for data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge core_clk_i);
    d = reg_rdata_i;
  endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench for the port interrupt status block.
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr, rd, irq;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] psel;
  logic [10:0] ev [2] = '{11'h000, 11'h000};
  logic [7:0] gpio = 8'h00;
  int num_errors = 0;
  int check_count = 0;
  // Events: encode, sequence, crc, sensor, length, count, buffer, csi,
  // parity, valid, lock.
  int bitn [11] = '{2, 1, 0, 3, 6, 5, 4, 3, 2, 1, 0};
  logic [7:0] clr [11] = '{8'h4E, 8'h4D, 8'h4D, 8'hDF, 8'h4E, 8'h4E,
    8'h4E, 8'h7A, 8'h4D, 8'h4D, 8'h4D};
  always #2 core_clk_i = ~core_clk_i;
  rpis_top DUT (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata),
    .encode_error_i({ev[1][0], ev[0][0]}),
    .sequence_error_i({ev[1][1], ev[0][1]}),
    .crc_error_i({ev[1][2], ev[0][2]}),
    .sensor_change_i({ev[1][3], ev[0][3]}),
    .line_length_change_i({ev[1][4], ev[0][4]}),
    .line_count_change_i({ev[1][5], ev[0][5]}),
    .buffer_overflow_i({ev[1][6], ev[0][6]}),
    .csi_error_i({ev[1][7], ev[0][7]}),
    .parity_error_i({ev[1][8], ev[0][8]}),
    .port_valid_i({ev[1][9], ev[0][9]}),
    .lock_i({ev[1][10], ev[0][10]}),
    .fwd_gpio_i(gpio), .port_select_o(psel), .irq_o(irq));
  rpis_host host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  // Pulse inputs go high for one cycle; level inputs just toggle.
  task automatic pulse(input int p, input int k);
    @(posedge core_clk_i);
    ev[p][k] <= ~ev[p][k];
    if (k < 9)
    begin
      @(posedge core_clk_i);
      ev[p][k] <= 1'b0;
    end
    @(posedge core_clk_i);
  endtask
  task automatic test_reset;
    host.wr(8'h4C, 8'h01);
    rd_chk(8'hDA, 8'h00);
    rd_chk(8'hDB, 8'h00);
    rd_chk(8'hDC, 8'h00);
    rd_chk(8'h00, 8'h00);
    chk({6'h00, psel}, 8'h01);
    $display("test_reset done");
  endtask
  task automatic test_flags;
    logic [7:0] d;
    for (int k = 0; k < 11; k++)
    begin
      pulse(0, k);
      rd_chk(k < 4 ? 8'hDA : 8'hDB, 8'h01 << bitn[k]);
      if (k == 3)
      begin
        host.rd(8'hDE, d);
        rd_chk(8'hDA, 8'h08);
      end
      host.rd(clr[k], d);
      rd_chk(k < 4 ? 8'hDA : 8'hDB, 8'h00);
    end
    chk({7'h00, irq}, 8'h00);
    $display("test_flags done");
  endtask
  task automatic test_ports;
    logic [7:0] d;
    host.wr(8'h4C, 8'h02);
    pulse(1, 4);
    rd_chk(8'hDB, 8'h40);
    host.wr(8'h4C, 8'h01);
    rd_chk(8'hDB, 8'h00);
    host.wr(8'h4C, 8'h02);
    host.rd(8'h4E, d);
    rd_chk(8'hDB, 8'h00);
    chk({6'h00, psel}, 8'h02);
    host.wr(8'h4C, 8'h03);
    pulse(1, 8);
    pulse(0, 8);
    host.rd(8'h4D, d);
    rd_chk(8'hDB, 8'h00);
    host.wr(8'h4C, 8'h02);
    rd_chk(8'hDB, 8'h04);
    host.rd(8'h4D, d);
    pulse(0, 8);
    host.wr(8'h4C, 8'h00);
    rd_chk(8'hDB, 8'h00);
    rd_chk(8'hDC, 8'h00);
    chk({6'h00, psel}, 8'h00);
    host.wr(8'h4C, 8'h01);
    rd_chk(8'hDB, 8'h04);
    host.rd(8'h4D, d);
    rd_chk(8'hDB, 8'h00);
    $display("test_ports done");
  endtask
  task automatic test_gpio;
    host.wr(8'h4C, 8'h01);
    host.wr(8'hDD, 8'h01);
    @(posedge core_clk_i);
    gpio <= 8'h01;
    repeat (8) @(posedge core_clk_i);
    chk({7'h00, irq}, 8'h01);
    rd_chk(8'hDA, 8'h10);
    rd_chk(8'hDC, 8'h11);
    rd_chk(8'hDC, 8'h01);
    rd_chk(8'hDA, 8'h00);
    chk({7'h00, irq}, 8'h00);
    gpio <= 8'h00;
    repeat (8) @(posedge core_clk_i);
    rd_chk(8'hDC, 8'h00);
    rd_chk(8'hDA, 8'h00);
    host.wr(8'hDD, 8'h02);
    gpio <= 8'h01;
    repeat (8) @(posedge core_clk_i);
    rd_chk(8'hDC, 8'h01);
    gpio <= 8'h00;
    repeat (8) @(posedge core_clk_i);
    rd_chk(8'hDA, 8'h10);
    rd_chk(8'hDC, 8'h10);
    rd_chk(8'hDC, 8'h00);
    rd_chk(8'hDA, 8'h00);
    $display("test_gpio done");
  endtask
  task automatic test_irq;
    logic [7:0] d;
    host.wr(8'hD9, 8'h01);
    pulse(0, 8);
    repeat (4) @(posedge core_clk_i);
    chk({7'h00, irq}, 8'h00);
    host.rd(8'h4D, d);
    pulse(0, 10);
    repeat (4) @(posedge core_clk_i);
    chk({7'h00, irq}, 8'h01);
    host.rd(8'h4D, d);
    repeat (4) @(posedge core_clk_i);
    chk({7'h00, irq}, 8'h00);
    host.wr(8'h4C, 8'h02);
    host.wr(8'hD9, 8'h01);
    pulse(1, 10);
    repeat (4) @(posedge core_clk_i);
    chk({7'h00, irq}, 8'h01);
    host.rd(8'h4D, d);
    repeat (4) @(posedge core_clk_i);
    chk({7'h00, irq}, 8'h00);
    $display("test_irq done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    test_reset();
    test_flags();
    test_ports();
    test_gpio();
    test_irq();
    end_of_test();
  end
  // Whole run needs well under two thousand cycles.
  initial
  begin
    #20000;
    num_errors++;
    end_of_test();
  end
endmodule
